/* rtl/cie_defines.svh */
// Purpose: offsets, field positions and fixed codes of the end-of-interrupt path
// Assumes: byte offsets from the base of the cpu interface register frame
// Notes:   definitions only
`ifndef CIE_DEFINES_SVH
`define CIE_DEFINES_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define CIE_OFF_ACK        16'h000c
`define CIE_OFF_EOI        16'h0010
`define CIE_OFF_HPP        16'h0018
`define CIE_OFF_AEOI       16'h0024
`define CIE_OFF_AHPP       16'h0028
`define CIE_OFF_DIR        16'h1000

// ----------------------------------------------------------------------------
// identifier fields
// ----------------------------------------------------------------------------
`define CIE_ID_MSB         23
`define CIE_NUM_MSB        9
`define CIE_SRC_LSB        10
`define CIE_SRC_W          3
`define CIE_NUM_SGI        16

// ----------------------------------------------------------------------------
// special identifiers and reset values
// ----------------------------------------------------------------------------
`define CIE_ID_SPUR_LO     24'h0003fc
`define CIE_ID_SPUR_HI     24'h0003ff
`define CIE_ID_NONE        24'h0003ff
`define CIE_ID_OTHER_GRP   24'h0003fe
`define CIE_RDATA_RST      32'h0000_0000

`endif

/* rtl/cie_pkg.sv */
// Purpose: carrier types of the end-of-interrupt path
// Assumes: nothing beyond the defines header
// Notes:   register request and answer, interrupt events
package cie_pkg;

  // ----------------------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        secure;
    logic [15:0] addr;
    logic [31:0] data;
  } cie_req_s;

  typedef struct packed {
    logic        rvalid;
    logic [31:0] rdata;
  } cie_rsp_s;

  // ----------------------------------------------------------------------------
  // events toward the distributor
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic [23:0] id;
  } cie_evt_s;

endpackage

/* rtl/cie_apr.sv */
// Purpose: one copy of the active-priorities state, a bit per priority level
// Assumes: at most one set or clear per cycle from the owner
// Notes:   lower level number is higher priority
module cie_apr #(
  parameter int PRIO_W = 5
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // updates
  input  wire logic              set_en,
  input  wire logic [PRIO_W-1:0] set_lvl,
  input  wire logic              clr_top,
  // state
  output logic                   any,
  output logic [PRIO_W-1:0]      top
);
  localparam int LEVELS = 1 << PRIO_W;

  logic [LEVELS-1:0] bits;
  logic [LEVELS-1:0] next_bits;

  function automatic logic [PRIO_W-1:0] lowest_set(input logic [LEVELS-1:0] v);
    logic [PRIO_W-1:0] r;
    r = '0;
    for (int i = LEVELS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = PRIO_W'(i);
      end
    end
    return r;
  endfunction

  assign any = |bits;
  assign top = lowest_set(bits);

  always_comb begin
    next_bits = bits;
    if (clr_top && any) begin
      next_bits[top] = 1'b0;
    end
    if (set_en) begin
      next_bits[set_lvl] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bits <= '0;
    end else begin
      bits <= next_bits;
    end
  end

endmodule

/* rtl/cie_hp_select.sv */
// Purpose: pick the highest-priority candidate interrupt
// Assumes: candidates already filtered by pending, enable and group
// Notes:   purely combinational
module cie_hp_select #(
  parameter int NUM_IRQ = 64,
  parameter int PRIO_W  = 5,
  parameter int IDX_W   = 6
) (
  // candidates
  input  wire logic [NUM_IRQ-1:0]        cand,
  input  wire logic [NUM_IRQ*PRIO_W-1:0] prio,
  // winner
  output logic                           found,
  output logic [IDX_W-1:0]               idx,
  output logic [PRIO_W-1:0]              win_prio
);
  if (IDX_W < 1 || ((NUM_IRQ - 1) >> IDX_W) != 0) begin : g_bad_idx
    $error("IDX_W too narrow for NUM_IRQ");
  end

  // strict less-than keeps the lowest index on a tie
  always_comb begin
    found    = 1'b0;
    idx      = '0;
    win_prio = '1;
    for (int i = 0; i < NUM_IRQ; i++) begin
      if (cand[i] && (!found || prio[i*PRIO_W +: PRIO_W] < win_prio)) begin
        found    = 1'b1;
        idx      = IDX_W'(i);
        win_prio = prio[i*PRIO_W +: PRIO_W];
      end
    end
  end

endmodule

/* rtl/cie_cpu_if.sv */
// Purpose: end-of-interrupt, deactivate, acknowledge and highest-pending paths
// Assumes: requests arrive on sys_clk, one per cycle; configuration from same domain
// Notes:   writes act at the request edge; read data and events follow one cycle later
//
// What this block does
// - split mode: deactivate write deactivates named interrupt
// - deactivate acts only when applicable split bit set
// - deactivate ignored when split bit clear
// - lone deactivate leaves active priority bit set
// - 32-bit registers, 24-bit identifier, upper zero
// - non-affinity: bits 12:10 carry sgi source
// - end-of-interrupt drops priority, deactivates unless split
// - end-of-interrupt ignores identifiers 1020 to 1023
// - secure end-of-interrupt of group 1 flagged, no deactivate; drops secure priority if highest
// - non-secure group 0 end flagged under secure split, no deactivate; drops non-secure priority if highest
// - end-of-interrupt group follows access security
// - two states: non-secure alias registers exist
// - split bit chosen by access security
// - highest-pending read returns id, changes nothing
// - non-secure read of group 0 returns 1023
// - secure or single-state group 1 returns 1022
// - nothing pending returns 1023; distributor-disabled groups skipped
// - group disabled at cpu interface returns 1023
// - valid acknowledge read moves interrupt to active
// - split bit selects drop-only or drop-and-deactivate
`include "cie_defines.svh"

module cie_cpu_if #(
  parameter int NUM_IRQ = 64,
  parameter int PRIO_W  = 5
) (
  // clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  // register access from the core
  input  cie_pkg::cie_req_s                reg_req,
  output cie_pkg::cie_rsp_s                reg_rsp,
  // configuration levels
  input  wire logic                        single_security_state,
  input  wire logic                        split_mode,
  input  wire logic                        secure_split_mode,
  input  wire logic                        nonsecure_split_mode,
  input  wire logic                        cpu_grp0_en,
  input  wire logic                        cpu_grp1_en,
  input  wire logic                        dist_grp0_en,
  input  wire logic                        dist_grp1_en,
  // interrupt state from the distributor
  input  wire logic [NUM_IRQ-1:0]          irq_pending,
  input  wire logic [NUM_IRQ-1:0]          irq_enable,
  input  wire logic [NUM_IRQ-1:0]          irq_group,
  input  wire logic [NUM_IRQ*PRIO_W-1:0]   irq_prio,
  input  wire logic [16*3-1:0]             sgi_source,
  // events and state
  output cie_pkg::cie_evt_s                ack_evt,
  output cie_pkg::cie_evt_s                deact_evt,
  output logic                             sys_err,
  output logic [NUM_IRQ-1:0]               irq_active
);
  import cie_pkg::*;

  localparam int IDX_W = $clog2(NUM_IRQ);

  // ----------------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------------
  if (NUM_IRQ < `CIE_NUM_SGI || NUM_IRQ > 1020) begin : g_bad_num
    $error("NUM_IRQ must lie between 16 and 1020");
  end
  if (PRIO_W < 1 || PRIO_W > 8) begin : g_bad_prio
    $error("PRIO_W must lie between 1 and 8");
  end

  // ----------------------------------------------------------------------------
  // identifier helpers
  // ----------------------------------------------------------------------------
  function automatic logic is_special(input logic [`CIE_ID_MSB:0] id);
    return id >= `CIE_ID_SPUR_LO && id <= `CIE_ID_SPUR_HI;
  endfunction

  // only the interrupt number selects state; source and reserved bits do not
  function automatic logic [`CIE_NUM_MSB:0] id_num(input logic [`CIE_ID_MSB:0] id);
    return id[`CIE_NUM_MSB:0];
  endfunction

  function automatic logic grp_on(input logic grp1, input logic en0, input logic en1);
    return grp1 ? en1 : en0;
  endfunction

  // ----------------------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------------------
  wire logic                 ds       = single_security_state;
  wire logic                 wr       = reg_req.valid & reg_req.write;
  wire logic                 rd       = reg_req.valid & ~reg_req.write;
  wire logic                 hit_ack  = reg_req.addr == `CIE_OFF_ACK;
  wire logic                 hit_eoi  = reg_req.addr == `CIE_OFF_EOI;
  wire logic                 hit_hpp  = reg_req.addr == `CIE_OFF_HPP;
  // aliases only exist with two security states
  wire logic                 hit_aeoi = ~ds & (reg_req.addr == `CIE_OFF_AEOI);
  wire logic                 hit_ahpp = ~ds & (reg_req.addr == `CIE_OFF_AHPP);
  wire logic                 hit_dir  = reg_req.addr == `CIE_OFF_DIR;
  wire logic                 ns_view  = ~ds & (hit_aeoi | hit_ahpp | ~reg_req.secure);

  // split bit for this access
  wire logic                 mode     = ds      ? split_mode :
                                        ns_view ? nonsecure_split_mode :
                                                  secure_split_mode;

  // ----------------------------------------------------------------------------
  // written identifier
  // ----------------------------------------------------------------------------
  wire logic [`CIE_ID_MSB:0]  wid   = reg_req.data[`CIE_ID_MSB:0];
  wire logic [`CIE_NUM_MSB:0] wnum  = id_num(wid);
  wire logic                  w_in  = (32'(wnum) < NUM_IRQ) & ~is_special(wid);
  wire logic [IDX_W-1:0]      widx  = IDX_W'(wnum);
  wire logic                  w_g1  = irq_group[widx];
  wire logic                  w_act = irq_active[widx];

  // ----------------------------------------------------------------------------
  // active-priorities copies
  // ----------------------------------------------------------------------------
  logic              s_any;
  logic              ns_any;
  logic [PRIO_W-1:0] s_top;
  logic [PRIO_W-1:0] ns_top;
  logic              s_set;
  logic              ns_set;
  logic              s_clr;
  logic              ns_clr;
  logic [PRIO_W-1:0] hp_prio;

  // ties between the copies go to the secure one
  wire logic sec_highest = s_any & (~ns_any | (s_top <= ns_top));
  wire logic ns_highest  = ns_any & ~sec_highest;

  cie_apr #(
    .PRIO_W (PRIO_W)
  ) u_apr_s (
    .sys_clk (sys_clk),
    .rst     (rst),
    .set_en  (s_set),
    .set_lvl (hp_prio),
    .clr_top (s_clr),
    .any     (s_any),
    .top     (s_top)
  );

  cie_apr #(
    .PRIO_W (PRIO_W)
  ) u_apr_ns (
    .sys_clk (sys_clk),
    .rst     (rst),
    .set_en  (ns_set),
    .set_lvl (hp_prio),
    .clr_top (ns_clr),
    .any     (ns_any),
    .top     (ns_top)
  );

  // ----------------------------------------------------------------------------
  // end-of-interrupt writes
  // ----------------------------------------------------------------------------
  wire logic eoi_wr   = wr & (hit_eoi | hit_aeoi) & w_in;
  // group must match the view: secure or single state is group 0
  wire logic eoi_ok   = eoi_wr & (w_g1 == ns_view);
  wire logic eoi_g1s  = eoi_wr & ~ds & ~ns_view & w_g1;
  wire logic eoi_g0ns = eoi_wr & ~ds & ns_view & ~w_g1 & secure_split_mode;
  wire logic eoi_deac = eoi_ok & ~mode & w_act;

  // ----------------------------------------------------------------------------
  // deactivate writes
  // ----------------------------------------------------------------------------
  wire logic dir_wr   = wr & hit_dir & w_in;
  wire logic dir_deac = dir_wr & mode & w_act;
  // split clear: ignored, flagged; inactive target also just dropped silently
  wire logic dir_bad  = dir_wr & ~mode;

  // ----------------------------------------------------------------------------
  // highest pending selection
  // ----------------------------------------------------------------------------
  logic             hp_found;
  logic [IDX_W-1:0] hp_idx;

  // active interrupts wait for deactivation before competing again
  wire logic [NUM_IRQ-1:0] cand = irq_pending & irq_enable & ~irq_active &
                                  ((irq_group & {NUM_IRQ{dist_grp1_en}}) |
                                   (~irq_group & {NUM_IRQ{dist_grp0_en}}));

  cie_hp_select #(
    .NUM_IRQ (NUM_IRQ),
    .PRIO_W  (PRIO_W),
    .IDX_W   (IDX_W)
  ) u_sel (
    .cand     (cand),
    .prio     (irq_prio),
    .found    (hp_found),
    .idx      (hp_idx),
    .win_prio (hp_prio)
  );

  wire logic                  hp_g1   = irq_group[hp_idx];
  wire logic                  hp_on   = grp_on(hp_g1, cpu_grp0_en, cpu_grp1_en);
  wire logic                  hp_sgi  = 32'(hp_idx) < `CIE_NUM_SGI;
  wire logic [5:0]            src_pos = 6'(hp_idx[3:0]) * 6'd3;
  wire logic [`CIE_SRC_W-1:0] hp_src  = hp_sgi ? sgi_source[src_pos +: `CIE_SRC_W] : '0;
  wire logic [`CIE_ID_MSB:0]  hp_id   = {11'h000, hp_src, 10'(hp_idx)};

  wire logic view_ok = hp_found & hp_on & (hp_g1 == ns_view);

  // identifier seen by this access, same for acknowledge and highest pending
  logic [`CIE_ID_MSB:0] view_id;
  always_comb begin
    if (!hp_found || !hp_on) begin
      view_id = `CIE_ID_NONE;
    end else if (!hp_g1 && ns_view) begin
      view_id = `CIE_ID_NONE;
    end else if (hp_g1 && !ns_view) begin
      view_id = `CIE_ID_OTHER_GRP;
    end else begin
      view_id = hp_id;
    end
  end

  // ----------------------------------------------------------------------------
  // acknowledge and priority bookkeeping
  // ----------------------------------------------------------------------------
  wire logic ack_take = rd & hit_ack & view_ok;

  assign s_set  = ack_take & ~hp_g1;
  assign ns_set = ack_take & hp_g1;
  // a lone deactivate never touches these copies
  assign s_clr  = (eoi_ok & ~w_g1) | (eoi_g1s & sec_highest);
  assign ns_clr = (eoi_ok & w_g1) | (eoi_g0ns & ns_highest);

  wire logic deac     = eoi_deac | dir_deac;
  wire logic next_err = eoi_g1s | eoi_g0ns | dir_bad;

  logic [NUM_IRQ-1:0] next_active;
  always_comb begin
    next_active = irq_active;
    if (deac) begin
      next_active[widx] = 1'b0;
    end
    if (ack_take) begin
      next_active[hp_idx] = 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // read data; write-only and unmapped offsets read zero
  // ----------------------------------------------------------------------------
  wire logic        rd_id     = hit_ack | hit_hpp | hit_ahpp;
  wire logic [31:0] next_data = rd_id ? {8'h00, view_id} : `CIE_RDATA_RST;

  // ----------------------------------------------------------------------------
  // state and registered outputs
  // ----------------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_active <= '0;
    end else begin
      irq_active <= next_active;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rsp <= '0;
    end else begin
      reg_rsp.rvalid <= rd;
      reg_rsp.rdata  <= rd ? next_data : `CIE_RDATA_RST;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_evt   <= '0;
      deact_evt <= '0;
      sys_err   <= 1'b0;
    end else begin
      ack_evt.valid   <= ack_take;
      ack_evt.id      <= hp_id;
      deact_evt.valid <= deac;
      deact_evt.id    <= wid;
      sys_err         <= next_err;
    end
  end

endmodule

/* testbench/cie_cpu_if_props.sv */
// Purpose: port-level checks of the end-of-interrupt block
// Assumes: one request per cycle, configuration steady around requests
// Notes:   bound to every cie_cpu_if instance
`include "cie_defines.svh"

module cie_cpu_if_props #(
  parameter int NUM_IRQ = 64,
  parameter int PRIO_W  = 5
) (
  // clock and reset
  input wire logic               sys_clk,
  input wire logic               rst,
  // register bus
  input cie_pkg::cie_req_s       reg_req,
  input cie_pkg::cie_rsp_s       reg_rsp,
  // configuration and state
  input wire logic               single_security_state,
  input wire logic               split_mode,
  input wire logic               secure_split_mode,
  input wire logic               nonsecure_split_mode,
  input wire logic [NUM_IRQ-1:0] irq_pending,
  input wire logic [NUM_IRQ-1:0] irq_group,
  input cie_pkg::cie_evt_s       deact_evt,
  input wire logic               sys_err,
  input wire logic [NUM_IRQ-1:0] irq_active
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------------
  wire logic [9:0]  num = reg_req.data[9:0];
  wire logic [23:0] id24 = reg_req.data[23:0];
  wire logic        one = single_security_state;
  wire logic        wr = reg_req.valid & reg_req.write;
  wire logic        rd = reg_req.valid & !reg_req.write;
  wire logic        alias_a = !one & (reg_req.addr == `CIE_OFF_AEOI);
  wire logic        is_dir = wr & (reg_req.addr == `CIE_OFF_DIR);
  wire logic        is_eoi = wr & ((reg_req.addr == `CIE_OFF_EOI) | alias_a);
  wire logic        ns_view = !one & (alias_a | !reg_req.secure);
  wire logic        split = one ? split_mode : ns_view ? nonsecure_split_mode : secure_split_mode;
  // out-of-range numbers never index the vectors
  wire logic        in_rng = num < NUM_IRQ;
  wire logic        act = in_rng && irq_active[num];
  wire logic        grp = in_rng && irq_group[num];
  wire logic        spec = (id24 >= `CIE_ID_SPUR_LO) && (id24 <= `CIE_ID_SPUR_HI);
  wire logic        is_hpp = rd & ((reg_req.addr == `CIE_OFF_HPP) |
                             (!one & (reg_req.addr == `CIE_OFF_AHPP)));
  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_read_answer: assert property (rd |=> reg_rsp.rvalid)
    else $error("read not answered in the next cycle");
  a_no_stray_rsp: assert property (!rd |=> !reg_rsp.rvalid)
    else $error("answer without a read");
  a_upper_zero: assert property (reg_rsp.rvalid |-> reg_rsp.rdata[31:24] == 8'h00)
    else $error("reserved read bits not zero");
  a_dir_ignored: assert property (is_dir && !split |=>
    sys_err && !deact_evt.valid && $stable(irq_active))
    else $error("deactivate acted with split bit clear");
  a_dir_deact: assert property (is_dir && split && act |=>
    deact_evt.valid && deact_evt.id == $past(id24) && !irq_active[$past(num)])
    else $error("deactivate did not take effect");
  a_eoi_special: assert property (is_eoi && spec |=>
    $stable(irq_active) && !deact_evt.valid && !sys_err)
    else $error("special end identifier acted");
  a_eoi_deact: assert property (is_eoi && !spec && !split && act &&
    (grp == ns_view) |=> deact_evt.valid && !irq_active[$past(num)])
    else $error("end without split did not deactivate");
  a_eoi_drop_only: assert property (is_eoi && split |=>
    $stable(irq_active) && !deact_evt.valid)
    else $error("end in split mode deactivated");
  a_secure_g1: assert property (is_eoi && !one && !ns_view && grp |=>
    sys_err && $stable(irq_active))
    else $error("secure end of group 1 not refused");
  a_hpp_idle: assert property (is_hpp && irq_pending == '0 |=>
    reg_rsp.rdata == 32'h0000_03ff)
    else $error("idle highest pending not 1023");
endmodule

bind cie_cpu_if cie_cpu_if_props #(.NUM_IRQ(NUM_IRQ), .PRIO_W(PRIO_W)) u_props (
  .sys_clk(sys_clk), .rst(rst), .reg_req(reg_req), .reg_rsp(reg_rsp),
  .single_security_state(single_security_state), .split_mode(split_mode),
  .secure_split_mode(secure_split_mode), .nonsecure_split_mode(nonsecure_split_mode),
  .irq_pending(irq_pending), .irq_group(irq_group), .deact_evt(deact_evt),
  .sys_err(sys_err), .irq_active(irq_active));

/* testbench/cie_core_model.sv */
// Purpose: processor core issuing register reads and writes
// Assumes: tasks are entered at a falling edge
// Notes:   a request is held until the next falling edge
`include "cie_defines.svh"

module cie_core_model (
  // clock
  input wire logic          sys_clk,
  // register bus
  output cie_pkg::cie_req_s reg_req,
  input  cie_pkg::cie_rsp_s reg_rsp
);
  timeunit 1ns;
  timeprecision 100ps;
  import cie_pkg::*;
  logic [31:0] acked[$];
  initial reg_req = '0;
  // only the memory-mapped registers are ever used
  task automatic put(input logic w, s, input logic [15:0] a, input logic [31:0] v);
    reg_req <= '{valid: 1'b1, write: w, secure: s, addr: a, data: v};
    @(negedge sys_clk);
  endtask
  task automatic wr(input logic s, input logic [15:0] a, input logic [31:0] v);
    put(1'b1, s, a, v);
  endtask
  task automatic rd(input logic s, input logic [15:0] a, output logic [31:0] v);
    put(1'b0, s, a, 32'h0);
    v = reg_rsp.rdata;
  endtask
  // released lines do not keep the old data
  task automatic idle;
    reg_req <= '{valid: 1'b0, write: 1'b0, secure: 1'b0, addr: 16'h0, data: ~reg_req.data};
    @(negedge sys_clk);
  endtask
  // valid identifiers are kept whole for the matching end
  task automatic ack(input logic s, output logic [31:0] v);
    rd(s, `CIE_OFF_ACK, v);
    if (v[9:0] < 10'h3fc) begin
      acked.push_back(v);
    end
  endtask
  task automatic eoi(input logic s, input logic [15:0] a);
    wr(s, a, acked.pop_back());
  endtask
endmodule

/* testbench/cie_cpu_if_tb_top.sv */
// Purpose: self-checking bench of the end-of-interrupt block
// Assumes: interrupts 2, 5 and 9 are the only ones ever pending
// Notes:   inputs change on the falling edge
`include "cie_defines.svh"

module cie_cpu_if_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import cie_pkg::*;
  typedef struct packed {
    logic [5:0]  cfg;
    logic [15:0] addr;
    logic [2:0]  p;
    logic [31:0] exp;
  } cie_row_s;
  // cfg: single, secure, cpu g0, cpu g1, dist g0, dist g1; p: irqs 9, 5, 2
  localparam cie_row_s ROWS[13] = '{
    '{6'h1f, `CIE_OFF_HPP, 3'b010, 32'h5}, '{6'h0f, `CIE_OFF_HPP, 3'b010, 32'h3ff},
    '{6'h1f, `CIE_OFF_HPP, 3'b100, 32'h3fe}, '{6'h0f, `CIE_OFF_HPP, 3'b100, 32'h9},
    '{6'h1f, `CIE_OFF_AHPP, 3'b100, 32'h9}, '{6'h2f, `CIE_OFF_HPP, 3'b100, 32'h3fe},
    '{6'h1f, `CIE_OFF_HPP, 3'b000, 32'h3ff}, '{6'h1f, `CIE_OFF_HPP, 3'b110, 32'h5},
    '{6'h0f, `CIE_OFF_HPP, 3'b101, 32'h1402}, '{6'h0b, `CIE_OFF_HPP, 3'b100, 32'h3ff},
    '{6'h0d, `CIE_OFF_HPP, 3'b110, 32'h9}, '{6'h1f, 16'h0040, 3'b100, 32'h0},
    '{6'h2f, `CIE_OFF_AHPP, 3'b100, 32'h0}};
  logic           sys_clk, rst, single, sec, split_c, split_s, split_ns;
  logic           cg0, cg1, dg0, dg1, err;
  logic [63:0]    pend, en, grp, active;
  logic [319:0]   prio;
  logic [47:0]    sgi_src;
  logic [31:0]    d;
  cie_req_s       req;
  cie_rsp_s       rsp;
  cie_evt_s       ack_e, deact_e;
  int             errors, n_tests;

  cie_core_model core (.sys_clk(sys_clk), .reg_req(req), .reg_rsp(rsp));
  cie_cpu_if DUT (
    .sys_clk(sys_clk), .rst(rst), .reg_req(req), .reg_rsp(rsp),
    .single_security_state(single), .split_mode(split_c),
    .secure_split_mode(split_s), .nonsecure_split_mode(split_ns),
    .cpu_grp0_en(cg0), .cpu_grp1_en(cg1), .dist_grp0_en(dg0), .dist_grp1_en(dg1),
    .irq_pending(pend), .irq_enable(en), .irq_group(grp), .irq_prio(prio),
    .sgi_source(sgi_src), .ack_evt(ack_e), .deact_evt(deact_e), .sys_err(err),
    .irq_active(active));

  function automatic logic [63:0] pmap(input logic [2:0] p);
    pmap = '0;
    pmap[2] = p[0];
    pmap[5] = p[1];
    pmap[9] = p[2];
  endfunction
  task automatic check(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // whole run is about 40 cycles
  initial begin
    #100us;
    errors++;
    stop_test();
  end

  initial begin
    {rst, single, sec, split_c, split_s, split_ns} = 6'h20;
    {cg0, cg1, dg0, dg1} = 4'hf;
    pend = '0;
    en = '1;
    grp = pmap(3'b101);
    prio = '0;
    prio[10+:5] = 5'h02;
    prio[25+:5] = 5'h01;
    prio[45+:5] = 5'h02;
    sgi_src = 48'h140;
    // count rising edges: the clock's first step from unknown is a falling edge
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    foreach (ROWS[i]) begin
      {single, sec, cg0, cg1, dg0, dg1} = ROWS[i].cfg;
      pend = pmap(ROWS[i].p);
      core.rd(sec, ROWS[i].addr, d);
      check(d, ROWS[i].exp);
    end
    check(active[31:0], 32'h0);
    // nested acknowledge, ended in reverse order
    {single, cg0, cg1, dg0, dg1} = 5'h0f;
    pend = pmap(3'b110);
    core.ack(1'b1, d);
    check(d, 32'h5);
    check({7'h0, ack_e}, 32'h0100_0005);
    core.ack(1'b0, d);
    check(d, 32'h9);
    check(active[31:0], 32'h220);
    core.eoi(1'b0, `CIE_OFF_EOI);
    check(active[31:0], 32'h20);
    split_s = 1'b1;
    core.wr(1'b0, `CIE_OFF_EOI, 32'h5);
    check({31'h0, err}, 32'h1);
    check(active[31:0], 32'h20);
    core.eoi(1'b1, `CIE_OFF_EOI);
    check(active[31:0], 32'h20);
    core.wr(1'b0, `CIE_OFF_DIR, 32'h5);
    check({31'h0, err}, 32'h1);
    check(active[31:0], 32'h20);
    core.wr(1'b1, `CIE_OFF_DIR, 32'hff00_0005);
    check(active[31:0], 32'h0);
    check({7'h0, deact_e}, 32'h0100_0005);
    // deactivate with no end before it
    core.ack(1'b1, d);
    core.wr(1'b1, `CIE_OFF_DIR, d);
    check({31'h0, deact_e.valid}, 32'h1);
    core.eoi(1'b1, `CIE_OFF_EOI);
    check(active[31:0], 32'h0);
    pend = pmap(3'b100);
    core.ack(1'b0, d);
    core.wr(1'b1, `CIE_OFF_EOI, 32'h9);
    check({31'h0, err}, 32'h1);
    core.wr(1'b0, `CIE_OFF_EOI, 32'h3fc);
    check({31'h0, err}, 32'h0);
    check(active[31:0], 32'h200);
    core.eoi(1'b1, `CIE_OFF_AEOI);
    check(active[31:0], 32'h0);
    // one security state uses the common split bit
    single = 1'b1;
    pend = pmap(3'b110);
    core.ack(1'b0, d);
    core.eoi(1'b0, `CIE_OFF_EOI);
    check(active[31:0], 32'h0);
    split_c = 1'b1;
    core.ack(1'b0, d);
    core.eoi(1'b0, `CIE_OFF_EOI);
    check(active[31:0], 32'h20);
    core.wr(1'b0, `CIE_OFF_DIR, 32'h5);
    check(active[31:0], 32'h0);
    // reset in mid-run clears the active state
    core.ack(1'b0, d);
    core.idle();
    rst = 1'b1;
    @(negedge sys_clk);
    check(active[31:0], 32'h0);
    rst = 1'b0;
    // interrupt 5 competes again only if reset cleared its active bit
    core.rd(1'b0, `CIE_OFF_HPP, d);
    check(d, 32'h5);
    stop_test();
  end
endmodule
